// File: include/bwp_if.sv
// Link between the bridge function and the host: config access and wake pin.
// Assumes the system pull-up on the wake line; resolved here from the enable.
`timescale 1ns/1ps
`default_nettype none

interface bwp_if;
    logic        cfg_req;
    logic        cfg_we;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic        cfg_ack;
    logic        pme_o;
    logic        pme_oe_n;
    wire logic   pme_n;

    // Open drain with pull-up: high unless the device drives
    assign pme_n = pme_oe_n ? 1'b1 : pme_o;

    modport dev (
        input  cfg_req,
        input  cfg_we,
        input  cfg_addr,
        input  cfg_wdata,
        output cfg_rdata,
        output cfg_ack,
        output pme_o,
        output pme_oe_n
    );

    modport host (
        output cfg_req,
        output cfg_we,
        output cfg_addr,
        output cfg_wdata,
        input  cfg_rdata,
        input  cfg_ack,
        input  pme_n
    );
endinterface

`default_nettype wire

// File: include/bwp_pkg.sv
// Shared constants and types for the bridge wake-event and power-state ends.
// Assumes a single 200 MHz core clock shared by both ends; no other context.
`default_nettype none

package bwp_pkg;

    localparam int SLOTS = 2;

    // Configuration register offsets seen by the host over the link
    localparam logic [7:0] CFG_CMD    = 8'h04;
    localparam logic [7:0] CFG_PMC    = 8'h40;
    localparam logic [7:0] CFG_PM_CONTROL_STATUS  = 8'h44;
    localparam logic [7:0] CFG_SCSTAT = 8'h48;

    // Command register bits
    localparam int CMD_W = 3;
    localparam logic [CMD_W-1:0] CMD_RESET = 3'h0;

    // pm_control_status layout
    localparam int CSR_PS_W   = 2;
    localparam int CSR_EN     = 8;
    localparam int CSR_EN_CLR = 9;
    localparam int CSR_PEND   = 15;

    // pm_capabilities layout
    localparam int PMC_VER_LO = 0;
    localparam int PMC_D1     = 25;
    localparam int PMC_D2     = 26;
    localparam int PMC_PME_LO = 27;
    localparam logic [2:0] PMC_VERSION = 3'h2;
    localparam logic [4:0] PMC_PME_SUP = 5'h1f;

    typedef enum logic [1:0] {
        PS_D0 = 2'h0,
        PS_D1 = 2'h1,
        PS_D2 = 2'h2,
        PS_D3 = 2'h3
    } bwp_pstate_t;

    // One bit per power state, D0 in bit 0; D2 is left out on purpose
    localparam logic [3:0] PS_SUPPORT = 4'hb;

    // Active level of each slot's card_status_change_line
    localparam logic [SLOTS-1:0] SLOT_ACT_HIGH = 2'h3;

    // Host controller registers, Avalon byte addresses
    localparam int AV_AW = 5;
    localparam logic [AV_AW-1:0] AV_HCMD  = 5'h00;
    localparam logic [AV_AW-1:0] AV_ADDR  = 5'h04;
    localparam logic [AV_AW-1:0] AV_WDATA = 5'h08;
    localparam logic [AV_AW-1:0] AV_RDATA = 5'h0c;
    localparam logic [AV_AW-1:0] AV_STAT  = 5'h10;
    localparam logic [AV_AW-1:0] AV_ISTAT = 5'h14;
    localparam logic [AV_AW-1:0] AV_IMASK = 5'h18;

    localparam int HC_RD    = 0;
    localparam int HC_WR    = 1;
    localparam int HC_SLEEP = 2;

    localparam int HS_BUSY  = 0;
    localparam int HS_PME   = 1;
    localparam int HS_LOWOK = 2;

    localparam int IRQ_W    = 2;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_DONE = 1;

    localparam logic [1:0] SEQ_LAST = 2'h2;

endpackage

`default_nettype wire

// File: rtl/bwp_device.sv
// Bridge function end: config registers, power state and wake-pin logic.
// Assumes the host holds cfg_req until cfg_ack and the card lines are async.
//
// Behaviour
// - Enabled wake routes card changes to wake pin
// - Convert card wake levels; originate own events
// - Unsupported state write keeps current state
// - Unsupported state write completes, no error
// - Host clears command enables before D3
// - Host idles function before low power
// - Host sets wake enable before sleeping
// - Host sleeps functions before bus power
// - System routes wake pin to wake logic
// - Wake pin is active-low open drain
// - Wake pin held until pending/enable cleared
// - Pending and enable clear only on one
// - Either slot's change drives the wake pin
`timescale 1ns/1ps
`default_nettype none

module bwp_device (
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    bwp_if.dev                              link,
    input  wire logic [bwp_pkg::SLOTS-1:0]  card_status_change_line,
    input  wire logic                       bridge_wake_event,
    output logic                            status_change_irq,
    output logic [1:0]                      power_state_field,
    output logic [bwp_pkg::CMD_W-1:0]       cmd_enables
);

    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdata;
        logic [bwp_pkg::CMD_W-1:0]    cmd;
        bwp_pkg::bwp_pstate_t         ps;
        logic                         wake_event_enable;
        logic                         wake_event_pending;
        logic [bwp_pkg::SLOTS-1:0]    scstat;
        // Edge history per slot
        logic [bwp_pkg::SLOTS-1:0]    active_prev;
        logic                         pme_o;
        logic                         pme_oe_n;
        logic                         irq;
    } bwp_dev_t;

    localparam bwp_dev_t DEV_RESET = '{
        ack:                1'b0,
        rdata:              32'h0000_0000,
        cmd:                bwp_pkg::CMD_RESET,
        ps:                 bwp_pkg::PS_D0,
        wake_event_enable:  1'b0,
        wake_event_pending: 1'b0,
        scstat:             '0,
        active_prev:        '0,
        pme_o:              1'b0,
        pme_oe_n:           1'b1,
        irq:                1'b0
    };

    bwp_dev_t r_reg;
    bwp_dev_t r_next;

    logic [bwp_pkg::SLOTS-1:0] line_sync;
    logic [bwp_pkg::SLOTS-1:0] line_active;
    logic [bwp_pkg::SLOTS-1:0] card_event;

    // Card lines are async to core_clk
    bwp_sync #(
        .W    (bwp_pkg::SLOTS),
        .INIT (~bwp_pkg::SLOT_ACT_HIGH)
    ) u_line_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (card_status_change_line),
        .dout     (line_sync)
    );

    // Each slot has its own sense; an event is the move into the active level
    genvar gi;
    generate
        for (gi = 0; gi < bwp_pkg::SLOTS; gi++) begin : g_slot
            assign line_active[gi] = line_sync[gi] == bwp_pkg::SLOT_ACT_HIGH[gi];
            assign card_event[gi]  = line_active[gi] & ~r_reg.active_prev[gi];
        end
    endgenerate

    // Fixed capabilities word
    function automatic logic [31:0] pmc_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[bwp_pkg::PMC_VER_LO +: 3] = bwp_pkg::PMC_VERSION;
        w[bwp_pkg::PMC_D1]          = bwp_pkg::PS_SUPPORT[bwp_pkg::PS_D1];
        w[bwp_pkg::PMC_D2]          = bwp_pkg::PS_SUPPORT[bwp_pkg::PS_D2];
        w[bwp_pkg::PMC_PME_LO +: 5] = bwp_pkg::PMC_PME_SUP;
        return w;
    endfunction

    always_comb begin
        logic                 take;
        logic [31:0]          rd;
        logic [31:0]          wd;
        bwp_pkg::bwp_pstate_t req_ps;

        take   = 1'b0;
        rd     = 32'h0000_0000;
        wd     = link.cfg_wdata;
        req_ps = bwp_pkg::bwp_pstate_t'(wd[bwp_pkg::CSR_PS_W-1:0]);
        r_next = r_reg;
        r_next.ack = 1'b0;

        // A request is taken once; the ack pulse blocks a second take
        take = link.cfg_req & ~r_reg.ack;

        if (take) begin
            r_next.ack = 1'b1;
            unique case (link.cfg_addr)
                bwp_pkg::CFG_CMD: begin
                    rd[bwp_pkg::CMD_W-1:0] = r_reg.cmd;

                    if (link.cfg_we) begin
                        r_next.cmd = wd[bwp_pkg::CMD_W-1:0];
                    end
                end

                bwp_pkg::CFG_PMC: begin
                    rd = pmc_word();
                end

                bwp_pkg::CFG_PM_CONTROL_STATUS: begin
                    rd[bwp_pkg::CSR_PS_W-1:0] = r_reg.ps;
                    rd[bwp_pkg::CSR_EN]       = r_reg.wake_event_enable;
                    rd[bwp_pkg::CSR_PEND]     = r_reg.wake_event_pending;

                    if (link.cfg_we) begin
                        // Unsupported states drop silently; the access still completes
                        if (bwp_pkg::PS_SUPPORT[req_ps]) begin
                            r_next.ps = req_ps;
                        end

                        // Zero bits leave both flags alone
                        if (wd[bwp_pkg::CSR_EN]) begin
                            r_next.wake_event_enable = 1'b1;
                        end
                        if (wd[bwp_pkg::CSR_EN_CLR]) begin
                            r_next.wake_event_enable = 1'b0;
                        end

                        if (wd[bwp_pkg::CSR_PEND]) begin
                            r_next.wake_event_pending = 1'b0;
                        end
                    end
                end

                bwp_pkg::CFG_SCSTAT: begin
                    rd[bwp_pkg::SLOTS-1:0] = r_reg.scstat;

                    if (link.cfg_we) begin
                        r_next.scstat = r_reg.scstat & ~wd[bwp_pkg::SLOTS-1:0];
                    end
                end

                default: begin
                    // Unmapped offsets read zero
                    rd = 32'h0000_0000;
                end
            endcase

            r_next.rdata = rd;
        end

        r_next.active_prev = line_active;

        // Events come after the clears so that a set in the same cycle wins
        if (r_reg.wake_event_enable) begin
            if ((|card_event) | bridge_wake_event) begin
                r_next.wake_event_pending = 1'b1;
            end
        end else begin
            r_next.scstat = r_next.scstat | card_event;
        end

        // Held purely by the sticky bits, not by the event source
        r_next.pme_o    = 1'b0;
        r_next.pme_oe_n = ~(r_next.wake_event_pending & r_next.wake_event_enable);
        r_next.irq      = |r_next.scstat;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            r_reg <= DEV_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from registers
    assign link.cfg_ack       = r_reg.ack;
    assign link.cfg_rdata     = r_reg.rdata;
    assign link.pme_o         = r_reg.pme_o;
    assign link.pme_oe_n      = r_reg.pme_oe_n;
    assign status_change_irq  = r_reg.irq;
    assign power_state_field  = r_reg.ps;
    assign cmd_enables        = r_reg.cmd;

endmodule // bwp_device

`default_nettype wire

// File: rtl/bwp_host.sv
// Host end: Avalon-MM register front, config access engine and wake input.
// Assumes one Avalon master; the wake pin arrives asynchronously.
`timescale 1ns/1ps
`default_nettype none

module bwp_host (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    bwp_if.host                            link,
    input  wire logic [bwp_pkg::AV_AW-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           irq,
    output logic                           system_control_irq,
    output logic                           bus_low_power_ok
);

    typedef enum logic [1:0] {
        H_IDLE = 2'h1,
        H_XFER = 2'h2
    } bwp_hst_t;

    typedef struct packed {
        logic                      wait_r;
        logic [31:0]               rdata;
        logic [7:0]                caddr;
        logic [31:0]               cwdata;
        logic [31:0]               crdata;
        bwp_hst_t                  st;
        logic                      seq;
        logic [1:0]                step;
        logic                      req;
        logic                      we;
        logic [7:0]                addr;
        logic [31:0]               wd;
        logic [bwp_pkg::IRQ_W-1:0] istat;
        logic [bwp_pkg::IRQ_W-1:0] imask;
        logic                      pme_prev;
        logic                      lowok;
        logic                      sci;
        logic                      irq;
    } bwp_host_t;

    localparam bwp_host_t HOST_RESET = '{
        wait_r: 1'b1, rdata: 32'h0000_0000, caddr: 8'h00, cwdata: 32'h0000_0000,
        crdata: 32'h0000_0000, st: H_IDLE, seq: 1'b0, step: 2'h0, req: 1'b0,
        we: 1'b0, addr: 8'h00, wd: 32'h0000_0000, istat: '0, imask: '0,
        pme_prev: 1'b1, lowok: 1'b0, sci: 1'b0, irq: 1'b0
    };

    bwp_host_t r_reg;
    bwp_host_t r_next;
    logic      pme_lvl;

    bwp_sync #(
        .W    (1),
        .INIT (1'b1)
    ) u_pme_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (link.pme_n),
        .dout     (pme_lvl)
    );

    always_comb begin
        logic        take;
        logic [31:0] rd;
        logic [31:0] csr;
        take = (avs_read | avs_write) & r_reg.wait_r;
        rd   = 32'h0000_0000;
        csr  = 32'h0000_0000;
        r_next = r_reg;
        r_next.wait_r = ~take;

        if (take & avs_read) begin
            unique case (avs_address)
                bwp_pkg::AV_ADDR:  rd[7:0] = r_reg.caddr;
                bwp_pkg::AV_WDATA: rd = r_reg.cwdata;
                bwp_pkg::AV_RDATA: rd = r_reg.crdata;
                bwp_pkg::AV_STAT: begin
                    rd[bwp_pkg::HS_BUSY]  = r_reg.st == H_XFER;
                    rd[bwp_pkg::HS_PME]   = ~pme_lvl;
                    rd[bwp_pkg::HS_LOWOK] = r_reg.lowok;
                end
                bwp_pkg::AV_ISTAT: begin
                    rd[bwp_pkg::IRQ_W-1:0] = r_reg.istat;
                    r_next.istat = '0;
                end
                bwp_pkg::AV_IMASK: rd[bwp_pkg::IRQ_W-1:0] = r_reg.imask;
                default:           rd = 32'h0000_0000;
            endcase
            r_next.rdata = rd;
        end

        if (take & avs_write) begin
            unique case (avs_address)
                bwp_pkg::AV_ADDR:  r_next.caddr = avs_writedata[7:0];
                bwp_pkg::AV_WDATA: r_next.cwdata = avs_writedata;
                bwp_pkg::AV_IMASK: r_next.imask = avs_writedata[bwp_pkg::IRQ_W-1:0];
                bwp_pkg::AV_HCMD: begin
                    // Only from idle, so nothing is outstanding when a sleep begins
                    if (r_reg.st == H_IDLE) begin
                        r_next.req = 1'b1;
                        r_next.st  = H_XFER;
                        r_next.seq = 1'b0;
                        if (avs_writedata[bwp_pkg::HC_SLEEP]) begin
                            r_next.seq  = 1'b1;
                            r_next.step = 2'h0;
                            r_next.we   = 1'b1;
                            r_next.addr = bwp_pkg::CFG_CMD;
                            r_next.wd   = 32'h0000_0000;
                        end else begin
                            r_next.we   = avs_writedata[bwp_pkg::HC_WR];
                            r_next.addr = r_reg.caddr;
                            r_next.wd   = r_reg.cwdata;
                        end
                    end
                end
                default: ;
            endcase
        end

        if (r_reg.st == H_XFER && link.cfg_ack) begin
            r_next.req = 1'b0;
            if (!r_reg.we) begin
                r_next.crdata = link.cfg_rdata;
            end
            if (r_reg.seq && r_reg.step != bwp_pkg::SEQ_LAST) begin
                r_next.step = r_reg.step + 2'h1;
                r_next.req  = 1'b1;
                r_next.addr = bwp_pkg::CFG_PM_CONTROL_STATUS;
                csr[bwp_pkg::CSR_EN] = 1'b1;
                if (r_reg.step == 2'h1) begin
                    csr[bwp_pkg::CSR_PS_W-1:0] = r_reg.cwdata[bwp_pkg::CSR_PS_W-1:0];
                end
                r_next.wd = csr;
            end else begin
                r_next.st = H_IDLE;
                r_next.istat[bwp_pkg::IRQ_DONE] = 1'b1;
                if (r_reg.seq) begin
                    // Bus may drop once the sleep sequence's last write asks for a state other than D0
                    r_next.lowok = r_reg.cwdata[bwp_pkg::CSR_PS_W-1:0] != bwp_pkg::PS_D0;
                end
            end
        end

        r_next.pme_prev = pme_lvl;
        if (r_reg.pme_prev && !pme_lvl) begin
            r_next.istat[bwp_pkg::IRQ_WAKE] = 1'b1;
        end
        r_next.sci = ~pme_lvl;
        r_next.irq = |(r_next.istat & r_next.imask);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            r_reg <= HOST_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.cfg_req       = r_reg.req;
    assign link.cfg_we        = r_reg.we;
    assign link.cfg_addr      = r_reg.addr;
    assign link.cfg_wdata     = r_reg.wd;
    assign avs_readdata       = r_reg.rdata;
    assign avs_waitrequest    = r_reg.wait_r;
    assign irq                = r_reg.irq;
    assign system_control_irq = r_reg.sci;
    assign bus_low_power_ok   = r_reg.lowok;

endmodule // bwp_host

`default_nettype wire

// File: rtl/bwp_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree.
// Assumes inputs from outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none

module bwp_sync #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bwp_sync_t;

    bwp_sync_t r_reg;
    bwp_sync_t r_next;

    always_comb begin
        r_next    = r_reg;
        r_next.s1 = din;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (r_reg.s2[i] == r_reg.s3[i]) begin
                r_next.q[i] = r_reg.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            r_reg <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
        end else begin
            r_reg <= r_next;
        end
    end

    assign dout = r_reg.q;
endmodule // bwp_sync

`default_nettype wire

// File: sim/bwp_monitor.sv
// Checker for the config link and the open-drain wake line between the two ends.
// Assumes one core_clk domain with synchronous active-low rstn.
`timescale 1ns/1ps
`default_nettype none

module bwp_monitor (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        cfg_req,
    input wire logic        cfg_we,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_ack,
    input wire logic        pme_o,
    input wire logic        pme_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic csr_rd;
    logic clr_wr;
    assign csr_rd = cfg_ack && !cfg_we && cfg_addr == bwp_pkg::CFG_PM_CONTROL_STATUS;
    // Only a taken clear write may release the pin; a same-cycle event can still hold it
    assign clr_wr = cfg_req && !cfg_ack && cfg_we && cfg_addr == bwp_pkg::CFG_PM_CONTROL_STATUS
                    && (cfg_wdata[bwp_pkg::CSR_PEND] || cfg_wdata[bwp_pkg::CSR_EN_CLR]);

    property p_ack_taken;
        cfg_req && !cfg_ack |=> cfg_ack;
    endproperty
    a_ack_taken: assert property (p_ack_taken) else $error("request not acked");

    property p_ack_single;
        cfg_ack |=> !cfg_ack;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");

    property p_drain_only;
        !pme_o;
    endproperty
    a_drain_only: assert property (p_drain_only) else $error("wake data not low");

    property p_pme_held;
        !pme_oe_n && !clr_wr |=> !pme_oe_n;
    endproperty
    a_pme_held: assert property (p_pme_held) else $error("wake pin released early");

    property p_pme_release;
        $rose(pme_oe_n) |-> $past(clr_wr);
    endproperty
    a_pme_release: assert property (p_pme_release) else $error("wake pin released without clear");

    property p_state_legal;
        csr_rd |-> bwp_pkg::PS_SUPPORT[cfg_rdata[1:0]];
    endproperty
    a_state_legal: assert property (p_state_legal) else $error("unsupported state reported");

    property p_caps;
        cfg_ack && !cfg_we && cfg_addr == bwp_pkg::CFG_PMC |->
            cfg_rdata[2:0] == bwp_pkg::PMC_VERSION && !cfg_rdata[bwp_pkg::PMC_D2] && cfg_rdata[bwp_pkg::PMC_D1];
    endproperty
    a_caps: assert property (p_caps) else $error("capabilities read wrong");

    property p_pin_vs_bits;
        csr_rd |-> (cfg_rdata[bwp_pkg::CSR_PEND] && cfg_rdata[bwp_pkg::CSR_EN]) == !$past(pme_oe_n);
    endproperty
    a_pin_vs_bits: assert property (p_pin_vs_bits) else $error("wake pin disagrees with bits");
endmodule // bwp_monitor

`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench: host end driven over Avalon, device end over card lines.
// Assumes the two ends meet in bwp_if and the monitor watches that link.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        core_clk = 1'b0;
    logic        rstn;
    logic [1:0]  card_line;
    logic        bwe;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        sci;
    logic        lowok;
    logic        sc_irq;
    logic [1:0]  ps;
    logic [2:0]  cmd_en;
    logic [31:0] q;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          seed = 95;
    int          n;
    int          s;
    int          m_ps = 0;
    int          m_en = 0;
    int          m_pend = 0;

    bwp_if link_if ();

    bwp_device bwp_device_inst (.core_clk(core_clk), .rstn(rstn), .link(link_if),
        .card_status_change_line(card_line), .bridge_wake_event(bwe),
        .status_change_irq(sc_irq), .power_state_field(ps), .cmd_enables(cmd_en));

    bwp_host bwp_host_inst (.core_clk(core_clk), .rstn(rstn), .link(link_if),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .system_control_irq(sci), .bus_low_power_ok(lowok));

    bwp_monitor bwp_monitor_inst (.core_clk(core_clk), .rstn(rstn), .cfg_req(link_if.cfg_req),
        .cfg_we(link_if.cfg_we), .cfg_addr(link_if.cfg_addr), .cfg_wdata(link_if.cfg_wdata),
        .cfg_rdata(link_if.cfg_rdata), .cfg_ack(link_if.cfg_ack), .pme_o(link_if.pme_o),
        .pme_oe_n(link_if.pme_oe_n));

    always #2.5 core_clk = ~core_clk;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // A run this short never nears the ceiling unless a handshake hangs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wait_idle();
        do begin
            av(1'b0, bwp_pkg::AV_STAT, 32'h0);
        end while (q[bwp_pkg::HS_BUSY] !== 1'b0);
    endtask

    task automatic cfg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        av(1'b1, bwp_pkg::AV_ADDR, 32'(a));
        av(1'b1, bwp_pkg::AV_WDATA, d);
        av(1'b1, bwp_pkg::AV_HCMD, 32'h1 << (wr ? bwp_pkg::HC_WR : bwp_pkg::HC_RD));
        wait_idle();
        if (!wr)
            av(1'b0, bwp_pkg::AV_RDATA, 32'h0);
    endtask

    task automatic chk_csr();
        cfg_op(1'b0, bwp_pkg::CFG_PM_CONTROL_STATUS, 32'h0);
        check(q & 32'h8103, (m_pend << 15) | (m_en << 8) | m_ps);
    endtask

    task automatic pme_is(input logic v);
        for (int k = 0; k < 30 && link_if.pme_n !== v; k++) begin
            @(posedge core_clk);
        end
        check(32'(link_if.pme_n), 32'(v));
    endtask

    task automatic own_event();
        @(posedge core_clk);
        bwe <= 1'b1;
        @(posedge core_clk);
        bwe <= 1'b0;
    endtask

    initial begin
        rstn          = 1'b0;
        card_line     = 2'h0;
        bwe           = 1'b0;
        avs_address   = 5'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        av(1'b0, bwp_pkg::AV_STAT, 32'h0);
        check(q, 32'h0);
        av(1'b0, 5'h1c, 32'h0);
        check(q, 32'h0);
        check(32'(link_if.pme_n), 32'h1);
        cfg_op(1'b0, bwp_pkg::CFG_PMC, 32'h0);
        check(32'(q[bwp_pkg::PMC_D2:bwp_pkg::PMC_D1]), 32'h1);
        chk_csr();
        $display("test reset values done");

        for (int i = 0; i < 12; i++) begin
            s = (i < 4) ? i : ($random(seed) & 3);
            cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, 32'(s));
            if (bwp_pkg::PS_SUPPORT[s])
                m_ps = s;
            chk_csr();
            check(32'(ps), m_ps);
        end
        $display("test power states done");

        card_line <= 2'h1;
        for (n = 0; n < 30 && sc_irq !== 1'b1; n++) begin
            @(posedge core_clk);
        end
        check(32'(sc_irq), 32'h1);
        check(32'(link_if.pme_n), 32'h1);
        card_line <= 2'h0;
        cfg_op(1'b1, bwp_pkg::CFG_SCSTAT, 32'h1);
        check(32'(sc_irq), 32'h0);
        $display("test wake disabled done");

        av(1'b1, bwp_pkg::AV_IMASK, 32'h1 << bwp_pkg::IRQ_WAKE);
        for (int k = 0; k < 2; k++) begin
            cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, (32'h1 << bwp_pkg::CSR_EN) | m_ps);
            m_en = 1;
            card_line <= 2'(1 << k);
            pme_is(1'b0);
            m_pend = 1;
            card_line <= 2'h0;
            for (n = 0; n < 30 && {irq, sci} !== 2'h3; n++) begin
                @(posedge core_clk);
            end
            check(32'({irq, sci}), 32'h3);
            repeat (20) @(posedge core_clk);
            check(32'(link_if.pme_n), 32'h0);
            cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, 32'(m_ps));
            chk_csr();
            av(1'b0, bwp_pkg::AV_ISTAT, 32'h0);
            check(q, 32'h3);
            cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, (32'h1 << bwp_pkg::CSR_PEND) | m_ps);
            m_pend = 0;
            pme_is(1'b1);
            check(32'(irq), 32'h0);
        end
        $display("test slot wake done");

        av(1'b1, bwp_pkg::AV_IMASK, 32'h0);
        own_event();
        pme_is(1'b0);
        m_pend = 1;
        repeat (10) @(posedge core_clk);
        check(32'(irq), 32'h0);
        cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, (32'h1 << bwp_pkg::CSR_EN_CLR) | m_ps);
        m_en = 0;
        pme_is(1'b1);
        chk_csr();
        cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, (32'h1 << bwp_pkg::CSR_PEND) | m_ps);
        m_pend = 0;
        own_event();
        repeat (10) @(posedge core_clk);
        check(32'(link_if.pme_n), 32'h1);
        chk_csr();
        $display("test own event done");

        cfg_op(1'b1, bwp_pkg::CFG_CMD, 32'h7);
        check(32'(cmd_en), 32'h7);
        av(1'b1, bwp_pkg::AV_WDATA, 32'(bwp_pkg::PS_D3));
        av(1'b1, bwp_pkg::AV_HCMD, 32'h1 << bwp_pkg::HC_SLEEP);
        av(1'b1, bwp_pkg::AV_HCMD, 32'h1 << bwp_pkg::HC_WR);
        wait_idle();
        m_ps = 3;
        m_en = 1;
        check(32'(cmd_en), 32'h0);
        check(32'({lowok, q[bwp_pkg::HS_LOWOK]}), 32'h3);
        chk_csr();
        cfg_op(1'b1, bwp_pkg::CFG_PM_CONTROL_STATUS, 32'(bwp_pkg::PS_D2));
        chk_csr();
        $display("test sleep sequence done");
        test_done();
    end
endmodule // testbench

`default_nettype wire
